// ---- pci_pkg.sv ----
// Purpose: Constants shared by the pin-change interrupt block
// Assumes: 32-bit AXI4-Lite register bus, one word per register
// Notes: Register offsets are byte addresses

`default_nettype none

package pci_pkg;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [4:0] ADDR_PA_RISE = 5'h00;
	localparam logic [4:0] ADDR_PA_FALL = 5'h04;
	localparam logic [4:0] ADDR_PA_FLAGS = 5'h08;
	localparam logic [4:0] ADDR_PB_RISE = 5'h0C;
	localparam logic [4:0] ADDR_PB_FALL = 5'h10;
	localparam logic [4:0] ADDR_PB_FLAGS = 5'h14;
	localparam logic [4:0] ADDR_INT_CTRL = 5'h18;
	localparam logic [4:0] ADDR_IRQ_STAT = 5'h1C;
	localparam int ADDR_W = 5;

	// ****************************************************************
	// Field layouts and reset values
	// ****************************************************************
	localparam logic [7:0] PA_MASK = 8'h3F;
	localparam logic [7:0] PB_MASK = 8'hF0;
	localparam logic [7:0] REG_RESET = 8'h00;
	// Control register: bit 3 master enable, bit 0 aggregate flag
	localparam int CTRL_MEN_BIT = 3;
	localparam int CTRL_AGG_BIT = 0;
	localparam logic CTRL_MEN_RESET = 1'b0;
	// Block status: bit 0 edge event seen, sticky, write one to clear
	localparam logic [7:0] STAT_MASK = 8'h01;

	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ****************************************************************
	// Synchroniser depth
	// ****************************************************************
	localparam int SYNC_STAGES = 2;

	// Write channel states
	typedef enum logic [1:0] {
		PCI_WR_IDLE = 2'b01,
		PCI_WR_RESP = 2'b10
	} pci_wr_e;

endpackage

`default_nettype wire

// ---- pci_edge.sv ----
// Purpose: Synchronise one 8-bit port and flag enabled edges
// Assumes: Pins are asynchronous to clk
// Notes: First sync stage is read only by the second

`default_nettype none

module pci_edge (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [7:0] pin_in,
	input wire logic [7:0] rise_en,
	input wire logic [7:0] fall_en,
	output logic [7:0] edge_hit
);

	logic [7:0] meta_reg;
	logic [7:0] sync_reg;
	logic [7:0] prev_reg;
	logic [2:0] primed_reg;
	wire logic [7:0] rise_w;
	wire logic [7:0] fall_w;

	// ****************************************************************
	// Two-stage synchroniser plus history stage
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			meta_reg <= 8'h00;
			sync_reg <= 8'h00;
			prev_reg <= 8'h00;
			primed_reg <= 3'h0;
		end else begin
			meta_reg <= pin_in;
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
			primed_reg <= {primed_reg[1:0], 1'b1};
		end
	end

	// Gated until sync and history both hold pin samples; the reset
	// zeros would otherwise fake an edge on a pin that idles high
	assign rise_w = sync_reg & ~prev_reg;
	assign fall_w = ~sync_reg & prev_reg;
	// Disabled polarity never reaches a flag
	assign edge_hit = primed_reg[2] ? ((rise_w & rise_en) | (fall_w & fall_en)) : 8'h00;

endmodule

`default_nettype wire

// ---- pci_top.sv ----
// Purpose: Pin-change interrupt controller for ports A and B
// Assumes: AXI4-Lite slave, 32-bit data, single clock
// Notes: One write and one read in flight at most

`default_nettype none

module pci_top (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [7:0] port_a_pin,
	input wire logic [7:0] port_b_pin,
	output logic pin_change_irq,
	output logic wake_req,
	output logic block_irq,
	input wire logic [4:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [4:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	// ****************************************************************
	// Registers
	// ****************************************************************
	logic [7:0] porta_rise_enable_reg;
	logic [7:0] porta_fall_enable_reg;
	logic [7:0] porta_change_flags_reg;
	logic [7:0] portb_rise_enable_reg;
	logic [7:0] portb_fall_enable_reg;
	logic [7:0] portb_change_flags_reg;
	logic pin_change_master_enable_reg;
	logic [7:0] irq_stat_reg;
	logic [7:0] irq_mask_reg;
	logic [7:0] porta_change_flags_next;
	logic [7:0] portb_change_flags_next;
	logic [7:0] irq_stat_next;

	// Write channel state
	pci_pkg::pci_wr_e wr_state_reg;
	logic aw_held_reg;
	logic w_held_reg;
	logic [4:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic [1:0] bresp_reg;

	// Read channel state
	logic rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;

	wire logic [7:0] hit_a;
	wire logic [7:0] hit_b;

	// ****************************************************************
	// Edge detectors, one per port
	// ****************************************************************
	pci_edge u_edge_a (
		.clk(clk),
		.rst_b(rst_b),
		.pin_in(port_a_pin),
		.rise_en(porta_rise_enable_reg),
		.fall_en(porta_fall_enable_reg),
		.edge_hit(hit_a)
	);

	pci_edge u_edge_b (
		.clk(clk),
		.rst_b(rst_b),
		.pin_in(port_b_pin),
		.rise_en(portb_rise_enable_reg),
		.fall_en(portb_fall_enable_reg),
		.edge_hit(hit_b)
	);

	// ****************************************************************
	// Write address and data capture
	// ****************************************************************
	// Ready is low while a channel is held, so each is taken once
	assign s_axi_awready = (wr_state_reg == pci_pkg::PCI_WR_IDLE) && !aw_held_reg;
	assign s_axi_wready = (wr_state_reg == pci_pkg::PCI_WR_IDLE) && !w_held_reg;

	wire logic aw_fire = s_axi_awvalid && s_axi_awready;
	wire logic w_fire = s_axi_wvalid && s_axi_wready;
	wire logic have_aw = aw_held_reg || aw_fire;
	wire logic have_w = w_held_reg || w_fire;
	wire logic wr_go = (wr_state_reg == pci_pkg::PCI_WR_IDLE) && have_aw && have_w;
	wire logic [4:0] wr_addr = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
	wire logic [31:0] wr_data_all = w_held_reg ? w_data_reg : s_axi_wdata;
	wire logic [3:0] wr_strb = w_held_reg ? w_strb_reg : s_axi_wstrb;
	// Lane 0 carries register bits; lane 1 only the status mask, other lanes ignored
	wire logic wr_lane0 = wr_go && wr_strb[0];
	wire logic [7:0] wr_byte = wr_data_all[7:0];

	// ****************************************************************
	// Write decode
	// ****************************************************************
	wire logic we_pa_rise = wr_lane0 && (wr_addr == pci_pkg::ADDR_PA_RISE);
	wire logic we_pa_fall = wr_lane0 && (wr_addr == pci_pkg::ADDR_PA_FALL);
	wire logic we_pa_flag = wr_lane0 && (wr_addr == pci_pkg::ADDR_PA_FLAGS);
	wire logic we_pb_rise = wr_lane0 && (wr_addr == pci_pkg::ADDR_PB_RISE);
	wire logic we_pb_fall = wr_lane0 && (wr_addr == pci_pkg::ADDR_PB_FALL);
	wire logic we_pb_flag = wr_lane0 && (wr_addr == pci_pkg::ADDR_PB_FLAGS);
	wire logic we_ctrl = wr_lane0 && (wr_addr == pci_pkg::ADDR_INT_CTRL);
	wire logic we_stat = wr_lane0 && (wr_addr == pci_pkg::ADDR_IRQ_STAT);
	// Mask sits in byte 1 of the status word
	wire logic we_mask = wr_go && wr_strb[1] && (wr_addr == pci_pkg::ADDR_IRQ_STAT);
	wire logic wr_mapped = (wr_addr[1:0] == 2'b00) && (wr_addr <= pci_pkg::ADDR_IRQ_STAT);

	// ****************************************************************
	// Flag update: software value first, hardware set OR'ed last
	// ****************************************************************
	// Set wins over a clearing write, whatever was written
	assign porta_change_flags_next = ((we_pa_flag ? wr_byte : porta_change_flags_reg)
		| hit_a) & pci_pkg::PA_MASK;
	assign portb_change_flags_next = ((we_pb_flag ? wr_byte : portb_change_flags_reg)
		| hit_b) & pci_pkg::PB_MASK;

	// Aggregate flag and gated interrupt
	wire logic agg_flag = |{porta_change_flags_reg, portb_change_flags_reg};
	assign pin_change_irq = agg_flag && pin_change_master_enable_reg;
	// Wake fires with the flag already stored in the same edge
	assign wake_req = pin_change_irq;

	// Block status: any new edge event, write one to clear, set wins
	wire logic [7:0] stat_set = {7'h00, |{hit_a, hit_b}};
	wire logic [7:0] stat_clr = we_stat ? wr_byte : 8'h00;
	assign irq_stat_next = ((irq_stat_reg & ~stat_clr) | stat_set) & pci_pkg::STAT_MASK;
	assign block_irq = |(irq_stat_reg & irq_mask_reg);

	// ****************************************************************
	// Configuration and flag registers
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			porta_rise_enable_reg <= pci_pkg::REG_RESET;
			porta_fall_enable_reg <= pci_pkg::REG_RESET;
			portb_rise_enable_reg <= pci_pkg::REG_RESET;
			portb_fall_enable_reg <= pci_pkg::REG_RESET;
			porta_change_flags_reg <= pci_pkg::REG_RESET;
			portb_change_flags_reg <= pci_pkg::REG_RESET;
			pin_change_master_enable_reg <= pci_pkg::CTRL_MEN_RESET;
			irq_stat_reg <= pci_pkg::REG_RESET;
			irq_mask_reg <= pci_pkg::REG_RESET;
		end else begin
			if (we_pa_rise) porta_rise_enable_reg <= wr_byte & pci_pkg::PA_MASK;
			if (we_pa_fall) porta_fall_enable_reg <= wr_byte & pci_pkg::PA_MASK;
			if (we_pb_rise) portb_rise_enable_reg <= wr_byte & pci_pkg::PB_MASK;
			if (we_pb_fall) portb_fall_enable_reg <= wr_byte & pci_pkg::PB_MASK;
			if (we_ctrl) pin_change_master_enable_reg <= wr_byte[pci_pkg::CTRL_MEN_BIT];
			if (we_mask) irq_mask_reg <= wr_data_all[15:8] & pci_pkg::STAT_MASK;
			porta_change_flags_reg <= porta_change_flags_next;
			portb_change_flags_reg <= portb_change_flags_next;
			irq_stat_reg <= irq_stat_next;
		end
	end

	// ****************************************************************
	// Write channel sequencing
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			wr_state_reg <= pci_pkg::PCI_WR_IDLE;
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			aw_addr_reg <= 5'h00;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
			bresp_reg <= pci_pkg::RESP_OKAY;
		end else begin
			unique case (wr_state_reg)
				pci_pkg::PCI_WR_IDLE: begin
					if (wr_go) begin
						aw_held_reg <= 1'b0;
						w_held_reg <= 1'b0;
						bresp_reg <= wr_mapped ? pci_pkg::RESP_OKAY : pci_pkg::RESP_SLVERR;
						wr_state_reg <= pci_pkg::PCI_WR_RESP;
					end else begin
						if (aw_fire) begin
							aw_held_reg <= 1'b1;
							aw_addr_reg <= s_axi_awaddr;
						end
						if (w_fire) begin
							w_held_reg <= 1'b1;
							w_data_reg <= s_axi_wdata;
							w_strb_reg <= s_axi_wstrb;
						end
					end
				end
				pci_pkg::PCI_WR_RESP: begin
					if (s_axi_bready) wr_state_reg <= pci_pkg::PCI_WR_IDLE;
				end
				default: wr_state_reg <= pci_pkg::PCI_WR_IDLE;
			endcase
		end
	end

	assign s_axi_bvalid = (wr_state_reg == pci_pkg::PCI_WR_RESP);
	assign s_axi_bresp = bresp_reg;

	// ****************************************************************
	// Read decode
	// ****************************************************************
	// Unimplemented bits come back zero because stores are masked
	logic [31:0] rd_word;
	logic rd_ok;
	always_comb begin
		rd_word = 32'h0000_0000;
		rd_ok = 1'b1;
		unique case (s_axi_araddr)
			pci_pkg::ADDR_PA_RISE: rd_word[7:0] = porta_rise_enable_reg;
			pci_pkg::ADDR_PA_FALL: rd_word[7:0] = porta_fall_enable_reg;
			pci_pkg::ADDR_PA_FLAGS: rd_word[7:0] = porta_change_flags_reg;
			pci_pkg::ADDR_PB_RISE: rd_word[7:0] = portb_rise_enable_reg;
			pci_pkg::ADDR_PB_FALL: rd_word[7:0] = portb_fall_enable_reg;
			pci_pkg::ADDR_PB_FLAGS: rd_word[7:0] = portb_change_flags_reg;
			pci_pkg::ADDR_INT_CTRL: begin
				rd_word[pci_pkg::CTRL_MEN_BIT] = pin_change_master_enable_reg;
				rd_word[pci_pkg::CTRL_AGG_BIT] = agg_flag;
			end
			pci_pkg::ADDR_IRQ_STAT: rd_word[15:0] = {irq_mask_reg, irq_stat_reg};
			default: rd_ok = 1'b0;
		endcase
	end

	// ****************************************************************
	// Read channel
	// ****************************************************************
	assign s_axi_arready = !rvalid_reg;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= pci_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && !rvalid_reg) begin
			rvalid_reg <= 1'b1;
			rdata_reg <= rd_word;
			rresp_reg <= rd_ok ? pci_pkg::RESP_OKAY : pci_pkg::RESP_SLVERR;
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;

endmodule

`default_nettype wire

// ---- pci_asserts.sv ----
// Purpose: Port-level checks for the pin-change block
// Assumes: One clock, synchronous active-low reset
// Notes: Bound onto pci_top, watches its ports only, inputs and outputs

`default_nettype none

module pci_asserts (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [7:0] port_a_pin,
	input wire logic [7:0] port_b_pin,
	input wire logic pin_change_irq,
	input wire logic wake_req,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// ****************************************************************
	// Helpers and properties
	// ****************************************************************
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	logic [3:0] since_pin;
	// Cycles since any pin moved, saturating so it never wraps
	always_ff @(posedge clk) begin
		if (!rst_b || $changed(port_a_pin) || $changed(port_b_pin))
			since_pin <= 4'h0;
		else if (since_pin != 4'hF)
			since_pin <= since_pin + 4'h1;
	end
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	wake_tracks_irq_a: assert property (wake_req == pin_change_irq)
		else $error("wake differs from irq");
	irq_rise_cause_a: assert property ($rose(pin_change_irq) |->
		$rose(s_axi_bvalid) || since_pin < 4'h6) else $error("irq rose without cause");
	irq_fall_cause_a: assert property ($fell(pin_change_irq) |->
		$rose(s_axi_bvalid) || $past(rst_b) == 1'b0) else $error("irq fell without write");
	reset_clears_a: assert property (disable iff (1'b0) !rst_b |=>
		!pin_change_irq && !s_axi_bvalid) else $error("reset left outputs set");
	wr_answer_a: assert property (wr_taken |=> s_axi_bvalid) else $error("no write response");
	rd_answer_a: assert property (rd_taken |=> s_axi_rvalid) else $error("no read response");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
endmodule

bind pci_top pci_asserts u_chk (.clk(clk), .rst_b(rst_b), .port_a_pin(port_a_pin),
	.port_b_pin(port_b_pin), .pin_change_irq(pin_change_irq), .wake_req(wake_req),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

`default_nettype wire

// ---- pci_pin_model.sv ----
// Purpose: Outside world driving the monitored port pins
// Assumes: Bench sets target levels just after an edge
// Notes: Pins move one cycle later and stay, so pulses are wide

`default_nettype none

module pci_pin_model (
	input wire logic clk,
	input wire logic [7:0] a_lvl,
	input wire logic [7:0] b_lvl,
	output logic [7:0] port_a_pin,
	output logic [7:0] port_b_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	// Registered so every level lasts at least one clock
	always @(posedge clk) begin
		port_a_pin <= a_lvl;
		port_b_pin <= b_lvl;
	end
endmodule

`default_nettype wire

// ---- pin_change_interrupt_tb_top.sv ----
// Purpose: Register-level test of the pin-change block
// Assumes: AXI4-Lite master tasks, one access at a time
// Notes: Waits are bounded; a hang ends the run

`default_nettype none

module pin_change_interrupt_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, irq, wake, blk, awready, wready, bvalid, arready, rvalid;
	logic rst_b = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic [7:0] a_lvl = 8'h00, b_lvl = 8'hFF, pa, pb;
	logic [4:0] awaddr = 5'h00, araddr = 5'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0] wstrb = 4'hF;
	logic [1:0] bresp, rresp;
	localparam logic [1:0] OK = pci_pkg::RESP_OKAY;
	int error_cnt = 0, checked = 0, i;

	pci_pin_model u_pins (.clk(clk), .a_lvl(a_lvl), .b_lvl(b_lvl), .port_a_pin(pa),
		.port_b_pin(pb));
	pci_top u_dut (.clk(clk), .rst_b(rst_b), .port_a_pin(pa), .port_b_pin(pb),
		.pin_change_irq(irq), .wake_req(wake), .block_irq(blk), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

	// 200 MHz clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// ****************************************************************
	// Bus and compare tasks
	// ****************************************************************
	task conclude();
		if (error_cnt == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// A used-up bound counts as a mismatch and ends the run
	task tmo(input int n);
		if (n >= 40) begin
			error_cnt++;
			conclude();
		end
	endtask

	// Both channels offered together, each dropped once taken; bready
	// comes only after bvalid is seen, so the slave must hold its answer
	task wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		logic ad, wd;
		ad = 1'b0;
		wd = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		for (n = 0; n < 40 && !(ad && wd); n++) begin
			@(posedge clk);
			ad = ad | awready;
			wd = wd | wready;
			awvalid <= !ad;
			wvalid <= !wd;
		end
		tmo(n);
		for (n = 0; n < 40; n++) begin
			@(posedge clk);
			if (bvalid)
				break;
		end
		tmo(n);
		bready <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge clk);
			if (bvalid)
				break;
		end
		tmo(n);
		bready <= 1'b0;
		chk({30'h0, bresp}, {30'h0, er});
	endtask

	// Late rready as well, so read data must stand until taken
	task rd(input logic [4:0] a, input logic [31:0] e, input logic [1:0] er);
		int n;
		araddr <= a;
		arvalid <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge clk);
			if (arready)
				break;
		end
		tmo(n);
		arvalid <= 1'b0;
		for (n = 0; n < 40; n++) begin
			@(posedge clk);
			if (rvalid)
				break;
		end
		tmo(n);
		rready <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge clk);
			if (rvalid)
				break;
		end
		tmo(n);
		rready <= 1'b0;
		chk(rdata, e);
		chk({30'h0, rresp}, {30'h0, er});
	endtask

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge clk);
		for (i = 0; i < 8; i++)
			rd(5'(i * 4), 32'h0, OK);
		rd(5'h01, 32'h0, pci_pkg::RESP_SLVERR);
		// Writable bits only; flags take a software write too
		for (i = 0; i < 6; i++) begin
			wr(5'(i * 4), 32'hFF, OK);
			rd(5'(i * 4), {24'h0, (i < 3) ? pci_pkg::PA_MASK : pci_pkg::PB_MASK}, OK);
		end
		wr(pci_pkg::ADDR_PA_FLAGS, 32'h0, OK);
		wr(pci_pkg::ADDR_PB_FLAGS, 32'h0, OK);
		rd(pci_pkg::ADDR_PA_FLAGS, 32'h0, OK);
		wr(pci_pkg::ADDR_PA_RISE, 32'h01, OK);
		wr(pci_pkg::ADDR_PA_FALL, 32'h00, OK);
		wr(pci_pkg::ADDR_PB_RISE, 32'h00, OK);
		wr(pci_pkg::ADDR_PB_FALL, 32'h80, OK);
		// Lane 0 off, then a misaligned address: neither may land
		wstrb <= 4'hE;
		wr(pci_pkg::ADDR_PA_RISE, 32'hFF, OK);
		wstrb <= 4'hF;
		wr(5'h02, 32'hFF, pci_pkg::RESP_SLVERR);
		rd(pci_pkg::ADDR_PA_RISE, 32'h01, OK);
		// Pin 0 and 1 rise on A, pin 7 and 6 fall on B; only one each enabled
		a_lvl <= 8'h03;
		b_lvl <= 8'h3F;
		repeat (6) @(posedge clk);
		rd(pci_pkg::ADDR_PA_FLAGS, 32'h01, OK);
		rd(pci_pkg::ADDR_PB_FLAGS, 32'h80, OK);
		a_lvl <= 8'h00;
		repeat (6) @(posedge clk);
		rd(pci_pkg::ADDR_INT_CTRL, 32'h01, OK);
		chk({31'h0, irq}, 32'h0);
		wr(pci_pkg::ADDR_INT_CTRL, 32'h08, OK);
		chk({30'h0, irq, wake}, 32'h3);
		wr(pci_pkg::ADDR_PA_FLAGS, 32'h0, OK);
		chk({31'h0, irq}, 32'h1);
		wr(pci_pkg::ADDR_PB_FLAGS, 32'h0, OK);
		chk({31'h0, irq}, 32'h0);
		rd(pci_pkg::ADDR_INT_CTRL, 32'h08, OK);
		// Block status: sticky, masked, write one to clear
		rd(pci_pkg::ADDR_IRQ_STAT, 32'h01, OK);
		chk({31'h0, blk}, 32'h0);
		wr(pci_pkg::ADDR_IRQ_STAT, 32'h100, OK);
		chk({31'h0, blk}, 32'h1);
		wr(pci_pkg::ADDR_IRQ_STAT, 32'h101, OK);
		chk({31'h0, blk}, 32'h0);
		rd(pci_pkg::ADDR_IRQ_STAT, 32'h100, OK);
		// Pin edge reaches the flag on the very edge that takes a clearing write
		a_lvl <= 8'h01;
		repeat (3) @(posedge clk);
		wr(pci_pkg::ADDR_PA_FLAGS, 32'h0, OK);
		rd(pci_pkg::ADDR_PA_FLAGS, 32'h01, OK);
		// Second reset in mid-run with enables and master set
		b_lvl <= 8'hFF;
		repeat (6) @(posedge clk);
		rst_b <= 1'b0;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge clk);
		rd(pci_pkg::ADDR_PB_RISE, 32'h0, OK);
		rd(pci_pkg::ADDR_PB_FLAGS, 32'h0, OK);
		rd(pci_pkg::ADDR_INT_CTRL, 32'h0, OK);
		conclude();
	end
endmodule

`default_nettype wire
